//--- tlmc_codec.sv
// test-loop message codec: parses test-control messages, keeps loop state, encodes replies
// assumes one received octet per rx transfer with rx_last on the final octet, and an apb master
//
// Summary of operation
// - drop messages with nonzero skip indicator
// - discriminator nibble must be binary 1111
// - only 0100xxxx message types are accepted
// - close: header, type, mode, optional setup
// - select bits 00 choose first loopback scheme
// - select bits 01 choose second loopback scheme
// - loop mode bit 3 is ignored
// - setup list holds at most five entries
// - entry: 16-bit uplink size, msb first
// - bearer identity low five bits, 5..31
// - uplink size only scheme one, no pdcp
// - commands only travel toward the device
// - replies are header and type only
// - activation reply type is 01000101
// - positioning reset 01001000 plus technology octet
// - technology zero is assisted satnav only
// - satnav reset clears stored aiding data
// - open opens loops and replies only when the ctrl bearers-up bit is set
`timescale 1ns/1ns
module tlmc_codec import tlmc_pkg::*; #(
    parameter int ENTRIES = MAX_ENTRIES
) (
    // clock, reset and freeze
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // received message octets
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    // reply octets
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // loop control
    output logic loop_closed,
    output logic [1:0] loop_mode,
    output logic ul_size_apply,
    output logic rb_test_mode,
    output logic pos_clear
);
    localparam logic [2:0] NENT = 3'(ENTRIES);

    tlmc_state_t st_q, st_d;
    logic [7:0] type_q, mode_q, tech_q, rem_q;
    logic bad_q;
    logic [1:0] oct_q;
    logic [2:0] idx_q, ent_cnt_q;
    logic [15:0] acc_q;
    logic [15:0] ent_size_q [ENTRIES];
    logic [4:0] ent_id_q [ENTRIES];
    logic [ENTRIES-1:0] ent_ok_q;
    logic [1:0] ctrl_q;
    logic [15:0] drops_q, poscnt_q;
    logic loop_closed_q, test_mode_q, pos_clear_q, ul_apply_q;
    logic [1:0] loop_mode_q;
    logic pend_q, rx_ready_q;
    logic [7:0] rep_type_q;

    tlmc_reply_if rep_if ();

    function automatic logic is_cmd(input logic [7:0] t);
        is_cmd = (t == MT_CLOSE) || (t == MT_OPEN) || (t == MT_ACT) || (t == MT_DEACT) || (t == MT_POS_RESET);
    endfunction

    // types that must carry one more mandatory octet
    function automatic logic needs_more(input logic [7:0] t);
        needs_more = (t == MT_CLOSE) || (t == MT_POS_RESET);
    endfunction

    function automatic logic [2:0] ent_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - REG_ENTRY0;
        ent_idx = off[4:2];
    endfunction

    // receive path decode
    wire logic take = ce && rx_valid && rx_ready_q;
    wire logic hdr_bad = (rx_data[7:4] != SKIP_NONE) || (rx_data[3:0] != PD_TEST);
    wire logic type_bad = (rx_data[7:4] != TYPE_FAMILY) || !is_cmd(rx_data);
    wire logic [7:0] cur_type = (st_q == ST_TYPE) ? rx_data : type_q;
    wire logic [7:0] cur_mode = (st_q == ST_MODE) ? rx_data : mode_q;
    wire logic [7:0] cur_tech = (st_q == ST_TECH) ? rx_data : tech_q;
    // bit 3 of the mode octet is never looked at
    wire logic [1:0] sel = {cur_mode[MODE_HIGH_BIT], cur_mode[MODE_LOW_BIT]};
    wire logic sel_ok = (sel == MODE_SCHEME1) || (sel == MODE_SCHEME2);
    wire logic ent_done = (st_q == ST_LIST) && (oct_q == ENTRY_LAST_OCT);
    wire logic ent_keep = ent_done && (idx_q < NENT);
    wire logic [2:0] nent = idx_q + 3'(ent_keep);
    wire logic drop_now = take && (((st_q == ST_HDR) && (hdr_bad || rx_last))
                               || ((st_q == ST_TYPE) && (type_bad || (rx_last && needs_more(rx_data)))));
    wire logic fin = take && rx_last && !drop_now && (st_q != ST_HDR) && !((st_q == ST_DRAIN) && bad_q);

    // completed message actions
    wire logic do_close = fin && (cur_type == MT_CLOSE) && sel_ok;
    wire logic do_open = fin && (cur_type == MT_OPEN) && ctrl_q[CTRL_BEARERS_UP];
    wire logic do_act = fin && (cur_type == MT_ACT);
    wire logic do_deact = fin && (cur_type == MT_DEACT);
    wire logic do_pos = fin && (cur_type == MT_POS_RESET) && (cur_tech == POS_TECH_SATNAV);
    wire logic rep_fire = do_close || do_open || do_act || do_deact;
    wire logic [7:0] rep_type_d = do_close ? MT_CLOSE_CMP : do_open ? MT_OPEN_CMP :
                                  do_act ? MT_ACT_CMP : MT_DEACT_CMP;
    wire logic pend_d = rep_fire || (pend_q && rep_if.busy);

    // apb decode
    wire logic apb_setup = psel && !penable;
    wire logic apb_wr = psel && penable && pready && pwrite && !pslverr;
    wire logic aligned = (paddr & ALIGN_MASK) == 8'h00;
    wire logic ent_hit = aligned && (paddr >= REG_ENTRY0) && (8'(paddr - REG_ENTRY0) < {3'h0, NENT, 2'h0});
    wire logic reg_hit = aligned && ((paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                                     (paddr == REG_DROPS) || (paddr == REG_POSCNT));
    wire logic [2:0] rsel = ent_idx(paddr);
    wire logic [31:0] status_word = {16'h0000, type_q, pend_q, ent_cnt_q, test_mode_q, loop_mode_q, loop_closed_q};
    wire logic [31:0] entry_word = ent_hit ? {7'h00, ent_ok_q[rsel], 3'h0, ent_id_q[rsel], ent_size_q[rsel]}
                                           : 32'h0000_0000;
    wire logic [31:0] rd_mux = (paddr == REG_CTRL) ? {30'h0000_0000, ctrl_q} :
                               (paddr == REG_STATUS) ? status_word :
                               (paddr == REG_DROPS) ? {16'h0000, drops_q} :
                               (paddr == REG_POSCNT) ? {16'h0000, poscnt_q} : entry_word;

    assign rep_if.req = pend_q;
    assign rep_if.msg_type = rep_type_q;
    assign rx_ready = rx_ready_q;
    assign loop_closed = loop_closed_q;
    assign loop_mode = loop_mode_q;
    assign ul_size_apply = ul_apply_q;
    assign rb_test_mode = test_mode_q;
    assign pos_clear = pos_clear_q;

    always_comb begin
        st_d = st_q;
        if (take) begin
            case (st_q)
                ST_HDR: st_d = hdr_bad ? ST_DRAIN : ST_TYPE;
                ST_TYPE: st_d = type_bad ? ST_DRAIN : (rx_data == MT_CLOSE) ? ST_MODE :
                                (rx_data == MT_POS_RESET) ? ST_TECH : ST_DRAIN;
                ST_MODE: st_d = (sel == MODE_SCHEME1) ? ST_LEN : ST_DRAIN;
                ST_LEN: st_d = (rx_data == LEN_NONE) ? ST_DRAIN : ST_LIST;
                ST_LIST: st_d = (rem_q == REM_ONE) ? ST_DRAIN : ST_LIST;
                ST_TECH: st_d = ST_DRAIN;
                ST_DRAIN: st_d = ST_DRAIN;
                default: st_d = ST_HDR;
            endcase
            if (rx_last) begin
                st_d = ST_HDR;
            end
        end
    end

    // parser state and field capture
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= ST_HDR;
            bad_q <= 1'b0;
            type_q <= 8'h00;
            mode_q <= 8'h00;
            tech_q <= 8'h00;
        end else if (ce) begin
            st_q <= st_d;
            if (take) begin
                bad_q <= (st_q == ST_HDR) ? drop_now : (bad_q || drop_now);
            end
            if (take && st_q == ST_TYPE) begin
                type_q <= rx_data;
            end
            if (take && st_q == ST_MODE) begin
                mode_q <= rx_data;
            end
            if (take && st_q == ST_TECH) begin
                tech_q <= rx_data;
            end
        end
    end

    // loopback setup list capture
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rem_q <= 8'h00;
            oct_q <= 2'h0;
            idx_q <= 3'h0;
            acc_q <= 16'h0000;
            ent_ok_q <= '0;
            for (int i = 0; i < ENTRIES; i++) begin
                ent_size_q[i] <= 16'h0000;
                ent_id_q[i] <= 5'h00;
            end
        end else if (ce && take) begin
            if (st_q == ST_MODE) begin
                idx_q <= 3'h0;
            end
            if (st_q == ST_LEN) begin
                rem_q <= rx_data;
                oct_q <= 2'h0;
            end
            if (st_q == ST_LIST) begin
                rem_q <= rem_q - REM_ONE;
                oct_q <= ent_done ? 2'h0 : oct_q + 2'h1;
                acc_q <= {acc_q[7:0], rx_data};
                idx_q <= nent;
            end
            if (ent_keep) begin
                ent_size_q[idx_q] <= acc_q;
                ent_id_q[idx_q] <= rx_data[4:0];
                ent_ok_q[idx_q] <= rx_data[4:0] >= RB_ID_MIN;
            end
        end
    end

    // loop state and reply hand-off
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            loop_closed_q <= 1'b0;
            loop_mode_q <= MODE_SCHEME1;
            ent_cnt_q <= 3'h0;
            test_mode_q <= 1'b0;
            pos_clear_q <= 1'b0;
            ul_apply_q <= 1'b0;
            pend_q <= 1'b0;
            rep_type_q <= 8'h00;
            rx_ready_q <= 1'b0;
        end else if (ce) begin
            if (do_close) begin
                loop_closed_q <= 1'b1;
                loop_mode_q <= sel;
                ent_cnt_q <= (sel == MODE_SCHEME1) ? nent : 3'h0;
            end else if (do_open) begin
                loop_closed_q <= 1'b0;
            end
            if (do_act) begin
                test_mode_q <= 1'b1;
            end else if (do_deact) begin
                test_mode_q <= 1'b0;
            end
            pos_clear_q <= do_pos;
            ul_apply_q <= loop_closed_q && (loop_mode_q == MODE_SCHEME1) && !ctrl_q[CTRL_PDCP];
            pend_q <= pend_d;
            if (rep_fire) begin
                rep_type_q <= rep_type_d;
            end
            rx_ready_q <= !pend_d;
        end
    end

    // apb slave, no wait states; drop counter write clears, a new drop wins
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl_q <= CTRL_RESET;
            drops_q <= 16'h0000;
            poscnt_q <= 16'h0000;
        end else if (ce) begin
            pready <= apb_setup;
            if (apb_setup) begin
                prdata <= (reg_hit || ent_hit) ? rd_mux : 32'h0000_0000;
                pslverr <= !(reg_hit || ent_hit);
            end
            if (apb_wr && paddr == REG_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end
            if (apb_wr && paddr == REG_DROPS) begin
                drops_q <= 16'(drop_now);
            end else if (drop_now) begin
                drops_q <= drops_q + 16'h0001;
            end
            if (apb_wr && paddr == REG_POSCNT) begin
                poscnt_q <= 16'(do_pos);
            end else if (do_pos) begin
                poscnt_q <= poscnt_q + 16'h0001;
            end
        end
    end

    tlmc_reply_enc u_enc (
        .clock(clock),
        .reset_n(reset_n),
        .ce(ce),
        .rep(rep_if.enc),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_last(tx_last),
        .tx_ready(tx_ready)
    );

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_open_done;
        !loop_closed_q && pend_q && rep_type_q == MT_OPEN_CMP;
    endsequence

    property p_skip_drop;
        (take && st_q == ST_HDR && rx_data[7:4] != SKIP_NONE && !rx_last) |=> (st_q == ST_DRAIN && bad_q);
    endproperty
    a_skip_drop: assert property (p_skip_drop) else $error("skip indicator not dropped");

    property p_no_reply_bad;
        (st_q == ST_DRAIN && bad_q) |-> !rep_fire;
    endproperty
    a_no_reply_bad: assert property (p_no_reply_bad) else $error("reply to dropped message");

    property p_pd_check;
        (take && st_q == ST_HDR && rx_data[3:0] != PD_TEST) |=> bad_q;
    endproperty
    a_pd_check: assert property (p_pd_check) else $error("bad discriminator accepted");

    property p_family;
        (take && st_q == ST_TYPE && rx_data[7:4] != TYPE_FAMILY) |=> bad_q;
    endproperty
    a_family: assert property (p_family) else $error("foreign message type accepted");

    property p_close_mode;
        (ce && do_close) |=> (loop_closed_q && loop_mode_q == $past(sel));
    endproperty
    a_close_mode: assert property (p_close_mode) else $error("loop mode not taken");

    property p_scheme2;
        (ce && do_close && sel == MODE_SCHEME2) |=> (loop_mode_q == MODE_SCHEME2 && ent_cnt_q == 3'h0);
    endproperty
    a_scheme2: assert property (p_scheme2) else $error("second scheme kept setup list");

    property p_max_entries;
        ent_cnt_q <= NENT && idx_q <= NENT;
    endproperty
    a_max_entries: assert property (p_max_entries) else $error("too many setup entries");

    property p_rb_valid;
        ent_ok_q[0] |-> ent_id_q[0] >= RB_ID_MIN;
    endproperty
    a_rb_valid: assert property (p_rb_valid) else $error("signalling bearer marked valid");

    property p_size_scheme1;
        (ce && loop_mode_q == MODE_SCHEME2) |=> !ul_size_apply;
    endproperty
    a_size_scheme1: assert property (p_size_scheme1) else $error("uplink size applied in scheme two");

    property p_pos_reserved;
        (ce && take && rx_last && st_q == ST_TECH && type_q == MT_POS_RESET && rx_data != POS_TECH_SATNAV)
            |=> !pos_clear;
    endproperty
    a_pos_reserved: assert property (p_pos_reserved) else $error("reserved technology acted on");

    property p_pos_clear;
        (ce && take && rx_last && st_q == ST_TECH && type_q == MT_POS_RESET && rx_data == POS_TECH_SATNAV)
            |=> pos_clear;
    endproperty
    a_pos_clear: assert property (p_pos_clear) else $error("satnav reset not issued");

    property p_open_reply;
        (ce && take && rx_last && st_q == ST_TYPE && rx_data == MT_OPEN && ctrl_q[CTRL_BEARERS_UP])
            |=> s_open_done;
    endproperty
    a_open_reply: assert property (p_open_reply) else $error("open not answered");
endmodule

//--- tlmc_pkg.sv
// shared constants and state type of the test-loop message codec
// assumes octets arrive most significant bit first, one octet per transfer
package tlmc_pkg;
    // header nibbles: skip indicator in bits 8..5, discriminator in bits 4..1
    localparam logic [3:0] PD_TEST = 4'hf;
    localparam logic [3:0] SKIP_NONE = 4'h0;
    localparam logic [3:0] TYPE_FAMILY = 4'h4;
    // message types
    localparam logic [7:0] MT_CLOSE = 8'h40;
    localparam logic [7:0] MT_CLOSE_CMP = 8'h41;
    localparam logic [7:0] MT_OPEN = 8'h42;
    localparam logic [7:0] MT_OPEN_CMP = 8'h43;
    localparam logic [7:0] MT_ACT = 8'h44;
    localparam logic [7:0] MT_ACT_CMP = 8'h45;
    localparam logic [7:0] MT_DEACT = 8'h46;
    localparam logic [7:0] MT_DEACT_CMP = 8'h47;
    localparam logic [7:0] MT_POS_RESET = 8'h48;
    localparam logic [7:0] POS_TECH_SATNAV = 8'h00;
    // loop mode octet
    localparam int MODE_LOW_BIT = 0;
    localparam int MODE_HIGH_BIT = 1;
    localparam logic [1:0] MODE_SCHEME1 = 2'h0;
    localparam logic [1:0] MODE_SCHEME2 = 2'h1;
    // loopback setup list
    localparam int MAX_ENTRIES = 5;
    localparam logic [1:0] ENTRY_LAST_OCT = 2'h2;
    localparam logic [4:0] RB_ID_MIN = 5'h05;
    localparam logic [7:0] LEN_NONE = 8'h00;
    localparam logic [7:0] REM_ONE = 8'h01;
    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DROPS = 8'h08;
    localparam logic [7:0] REG_POSCNT = 8'h0c;
    localparam logic [7:0] REG_ENTRY0 = 8'h10;
    localparam logic [7:0] ALIGN_MASK = 8'h03;
    localparam int CTRL_BEARERS_UP = 0;
    localparam int CTRL_PDCP = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    typedef enum logic [2:0] {
        ST_HDR = 3'b000,
        ST_TYPE = 3'b001,
        ST_MODE = 3'b010,
        ST_LEN = 3'b011,
        ST_LIST = 3'b100,
        ST_TECH = 3'b101,
        ST_DRAIN = 3'b110
    } tlmc_state_t;
endpackage

//--- tlmc_reply_if.sv
// reply request handed from the message parser to the reply encoder
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface tlmc_reply_if;
    logic req;
    logic [7:0] msg_type;
    logic busy;
    modport ctl (output req, output msg_type, input busy);
    modport enc (input req, input msg_type, output busy);
endinterface

//--- tlmc_reply_enc.sv
// reply encoder: sends header octet then message type octet
// assumes the downstream sink may stall with tx_ready low
`timescale 1ns/1ns
module tlmc_reply_enc import tlmc_pkg::*; (
    // clock, reset and freeze
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ce,
    // reply request
    tlmc_reply_if.enc rep,
    // reply octets
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready
);
    logic busy_q;
    logic [7:0] type_q;
    wire logic start = rep.req && !busy_q;
    wire logic sent = tx_valid && tx_ready;

    assign rep.busy = busy_q;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            type_q <= 8'h00;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else if (ce) begin
            if (start) begin
                busy_q <= 1'b1;
                type_q <= rep.msg_type;
                tx_valid <= 1'b1;
                tx_data <= {SKIP_NONE, PD_TEST};
                tx_last <= 1'b0;
            end else if (sent && !tx_last) begin
                tx_data <= type_q;
                tx_last <= 1'b1;
            end else if (sent) begin
                busy_q <= 1'b0;
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_hdr_out;
        tx_valid && !tx_last && tx_data == {SKIP_NONE, PD_TEST};
    endsequence

    property p_hdr_first;
        (ce && start) |=> s_hdr_out;
    endproperty
    a_hdr_first: assert property (p_hdr_first) else $error("reply header octet wrong");

    property p_act_reply;
        (ce && start && rep.msg_type == MT_ACT_CMP) |=> s_hdr_out ##[1:40] (tx_last && tx_data == MT_ACT_CMP);
    endproperty
    a_act_reply: assert property (p_act_reply) else $error("activation reply type wrong");

    property p_only_replies;
        (tx_valid && tx_last) |-> tx_data[0] && tx_data[7:4] == TYPE_FAMILY;
    endproperty
    a_only_replies: assert property (p_only_replies) else $error("device sent a command type");
endmodule

//--- tlmc_sim.sv
// test system model: sends command octets to the codec and sinks its replies
// assumes send is called just after a rising edge of clock
`timescale 1ns/1ns
module tlmc_sim (
    // clock
    input wire logic clock,
    // command octets
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    // reply octets
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic [8:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        tx_ready = 1'b0;
    end
    // sink stalls every other cycle when slow
    always @(posedge clock) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back({tx_last, tx_data});
        end
    end
    // commands only flow toward the device; data line inverted once released
    task automatic send(input logic [7:0] m[$], output logic ok);
        int n;
        ok = 1'b1;
        foreach (m[i]) begin
            rx_valid <= 1'b1;
            rx_data <= m[i];
            rx_last <= (i == m.size() - 1);
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (rx_ready !== 1'b1 && n < 50);
            if (n >= 50) ok = 1'b0;
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

//--- test_loop_message_codec_bench.sv
// bench for the test-loop message codec: message table, then hand-written cases
// assumes tlmc_sim on the message side and the bench as apb master
`timescale 1ns/1ns
module test_loop_message_codec_bench import tlmc_pkg::*; ();
    typedef struct {logic [63:0] m; int len; logic [7:0] rep; logic [4:0] st;} tlmc_row_t;
    logic clock, reset_n, ce, psel, penable, pwrite, pready, pslverr, e, ok;
    logic [7:0] paddr, rx_data, tx_data;
    logic [31:0] pwdata, prdata, r;
    logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic loop_closed, ul_size_apply, rb_test_mode, pos_clear;
    logic [1:0] loop_mode;
    logic [7:0] q[$];
    int n_fail = 0, compares = 0, n_pos = 0;
    // st is {closed, mode, size apply, test mode}
    tlmc_row_t rows[12] = '{
        '{64'h0f4001, 3, 8'h41, 5'b10100},
        '{64'h0f400803123405, 7, 8'h41, 5'b10010},
        '{64'h1f42, 2, 8'h00, 5'b10010},
        '{64'h0e42, 2, 8'h00, 5'b10010},
        '{64'h0f22, 2, 8'h00, 5'b10010},
        '{64'h0f44, 2, 8'h45, 5'b10011},
        '{64'h0f42, 2, 8'h43, 5'b00001},
        '{64'h0f42, 2, 8'h43, 5'b00001},
        '{64'h0f46, 2, 8'h47, 5'b00000},
        '{64'h0f4800, 3, 8'h00, 5'b00000},
        '{64'h0f4801, 3, 8'h00, 5'b00000},
        '{64'h0f4002, 3, 8'h00, 5'b00000}};
    tlmc_codec dut (.clock(clock), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .loop_closed(loop_closed), .loop_mode(loop_mode),
        .ul_size_apply(ul_size_apply), .rb_test_mode(rb_test_mode), .pos_clear(pos_clear));
    tlmc_sim sim (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) if (pos_clear === 1'b1) n_pos++;
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    task automatic hang(input string nm);
        $display("[ERR] %s expected answer seen none", nm);
        n_fail++;
        give_verdict();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n >= 50) hang("pready");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic er, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, r);
        chk({nm, " err"}, {31'h0, er}, {31'h0, e});
    endtask
    task automatic run(input logic [7:0] rep);
        int n;
        sim.got.delete();
        sim.send(q, ok);
        if (ok !== 1'b1) hang("rx_ready");
        n = 0;
        while (sim.got.size() < 2 && n < 40) begin
            @(posedge clock);
            n++;
        end
        @(negedge clock);
        chk("reply octets", (rep == 8'h00) ? 0 : 2, sim.got.size());
        if (rep != 8'h00 && sim.got.size() == 2) begin
            chk("reply header", 32'h00f, {23'h0, sim.got[0]});
            chk("reply type", {23'h0, 1'b1, rep}, {23'h0, sim.got[1]});
        end
        @(posedge clock);
    endtask
    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(REG_CTRL, 32'h0, 1'b0, "ctrl reset");
        apb(1'b1, REG_CTRL, 32'h1);
        foreach (rows[i]) begin
            q.delete();
            for (int k = rows[i].len - 1; k >= 0; k--) q.push_back(rows[i].m[k * 8 +: 8]);
            run(rows[i].rep);
            chk("loop state", rows[i].st, {loop_closed, loop_closed ? loop_mode : 2'h0, ul_size_apply,
                rb_test_mode});
            $display("row %0d done", i);
        end
        chk("satnav clears", 1, n_pos);
        rd(REG_POSCNT, 32'h1, 1'b0, "pos count");
        rd(REG_ENTRY0, 32'h01051234, 1'b0, "entry0");
        apb(1'b1, REG_CTRL, 32'h3);
        q = '{8'h0f, 8'h40, 8'h00, 8'h00};
        run(8'h41);
        chk("pdcp no apply", 32'h2, {loop_closed, ul_size_apply});
        sim.slow = 1'b1;
        q = '{8'h0f, 8'h40, 8'h00, 8'h0f};
        for (int k = 0; k < 5; k++) q = {q, 8'hff, 8'(k), 8'(k + 4)};
        run(8'h41);
        sim.slow = 1'b0;
        rd(REG_ENTRY0, 32'h0004ff00, 1'b0, "entry0 low id");
        rd(REG_ENTRY0 + 8'h10, 32'h0108ff04, 1'b0, "entry4");
        $display("list test done");
        apb(1'b1, REG_CTRL, 32'h0);
        q = '{8'h0f, 8'h42};
        run(8'h00);
        chk("open ignored", 32'h1, {31'h0, loop_closed});
        rd(REG_STATUS, 32'h00004251, 1'b0, "status");
        rd(8'h40, 32'h0, 1'b1, "unmapped");
        rd(REG_DROPS, 32'h3, 1'b0, "drops");
        apb(1'b1, REG_DROPS, 32'h0);
        rd(REG_DROPS, 32'h0, 1'b0, "drops cleared");
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        chk("reset state", 32'h0, {loop_closed, loop_mode, rb_test_mode, tx_valid});
        $display("register and reset tests done");
        give_verdict();
    end
endmodule
